// [design/sst_pkg.sv]
// shared constants and types for the i2c slave status tracker
// assumes a 32-bit apb slave port with an 8-bit byte address
package sst_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int APB_AW = 8;
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_ALT = 8'h08;
  localparam logic [7:0] OFS_ID0 = 8'h0c;
  localparam logic [7:0] OFS_RXD = 8'h1c;
  localparam int NUM_IDS = 4;

  // ****************************************
  // control and receive data register fields
  // ****************************************
  localparam int CTRL_SEN = 0;
  localparam int CTRL_GCEN = 2;
  localparam int CTRL_HGCEN = 3;
  localparam int CTRL_GCCLR = 4;
  localparam int CTRL_SSENI = 8;
  localparam logic [15:0] CTRL_WMASK = 16'h010d;
  localparam int RXD_VALID = 8;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [7:0] ALT_RST = 8'h00;
  localparam logic [6:0] ID_RST = 7'h00;
  localparam logic [7:0] RXD_RST = 8'h00;

  // ****************************************
  // bus codes
  // ****************************************
  localparam logic [7:0] START_BYTE = 8'h01;
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [7:0] GC_RESET = 8'h06;
  localparam logic [7:0] GC_PROG = 8'h04;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [1:0] {
    GCK_NONE = 2'b00,
    GCK_RESET = 2'b01,
    GCK_PROG = 2'b10,
    GCK_ALT = 2'b11
  } sst_gck_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b10,
    ST_SKIP = 2'b11
  } sst_state_t;

  // status word, bit 15 down to bit 0
  typedef struct packed {
    logic rsvd;
    logic start;
    logic reps;
    logic [1:0] mid;
    logic ss;
    sst_gck_t gck;
    logic gc;
    logic [6:0] low;
  } sst_status_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } sst_bus_ev_t;

endpackage : sst_pkg

// [design/sst_sync.sv]
// three-stage synchroniser for one bus line
// assumes din is asynchronous to clock; idle level of the line is high
`timescale 1ns/1ps
module sst_sync (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // line
  input wire logic din,
  output logic dout
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;

  // level only moves once stages two and three agree
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      lvl_q <= 1'b1;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
      begin
        lvl_q <= s3_q;
      end
    end
  end

  assign dout = lvl_q;

endmodule : sst_sync

// [design/sst_tracker.sv]
// i2c slave status tracker: bus receiver, status flags and apb registers
// assumes scl/sda are open-drain pins from another clock domain, and a
// single apb master on the same clock as this block
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps

// Behaviour
// - start flag bit 14 sets on start plus address matching a slave id
// - start flag also sets on receiving the start byte 0x01
// - with general call enabled, address 0x00 sets the start flag
// - stop condition clears the start flag
// - repeated start sets flag bit 13
// - repeated start flag clears on stop or any status read
// - field 12:11 gives index of matching slave id register
// - stop after a matched start sets flag bit 10
// - interrupt raised while that flag is set and stop irq enabled
// - status read clears the stop-after-start flag
// - field 9:8 encodes general call kind none/reset/program/alternate
// - writing one to general call clear clears the kind field
// - general call reset loads the kind field with reset rather than clearing it
// - general call flag bit 7 sets on a reset, program or enabled hardware general call command
// - general call reset returns interface registers to defaults; here the receive data byte keeps its value and only its valid bit clears
// - hardware general call puts second byte in receive register
// - writing one to general call clear clears the general call flag
// - general call data 0x06 means reset and program address
// - general call data 0x04 means program address
// - hardware general call needs both general call enables set
module sst_tracker (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sst_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // i2c pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // interrupt
  output logic stop_irq
);

  // ****************************************
  // line synchronisers and bus events
  // ****************************************
  logic scl_s;
  logic sda_s;
  logic scl_prev_q;
  logic sda_prev_q;
  sst_pkg::sst_bus_ev_t ev;

  sst_sync u_scl_sync (
    .clock(clock),
    .rst(rst),
    .din(scl_i),
    .dout(scl_s)
  );

  sst_sync u_sda_sync (
    .clock(clock),
    .rst(rst),
    .din(sda_i),
    .dout(sda_s)
  );

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  assign ev.start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign ev.stop = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  assign ev.rise = scl_s & ~scl_prev_q;
  assign ev.fall = ~scl_s & scl_prev_q;

  // ****************************************
  // registers
  // ****************************************
  sst_pkg::sst_state_t state_q;
  sst_pkg::sst_state_t next_state;
  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic ack_slot_q;
  logic ack_pend_q;
  logic sda_oe_q;
  logic gc_phase_q;
  logic session_hit_q;
  logic start_q;
  logic reps_q;
  logic [1:0] mid_q;
  logic ss_q;
  sst_pkg::sst_gck_t gck_q;
  logic gc_q;
  logic stop_irq_q;
  logic [15:0] ctrl_q;
  logic [7:0] alt_q;
  logic [6:0] id_q [sst_pkg::NUM_IDS];
  logic [7:0] rxd_q;
  logic rxd_valid_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // ****************************************
  // byte receiver decode
  // ****************************************
  logic rx_bit;
  logic byte_done;
  logic [7:0] rx_byte;
  logic is_addr;
  logic is_data;
  logic hit_start_byte;
  logic hit_gc_addr;
  logic hit_id;
  logic [sst_pkg::NUM_IDS-1:0] id_eq;
  logic [1:0] id_idx;
  logic gc_cmd;
  logic gc_rst_cmd;
  logic gc_prog_cmd;
  logic gc_hw_cmd;
  logic gc_any;
  logic ack_now;
  logic bus_busy;

  assign bus_busy = (state_q != sst_pkg::ST_IDLE);
  assign rx_bit = ev.rise & ~ack_slot_q
    & (state_q == sst_pkg::ST_ADDR | state_q == sst_pkg::ST_DATA);
  assign byte_done = rx_bit & (bit_cnt_q == sst_pkg::LAST_BIT);
  assign rx_byte = {shift_q, sda_s};
  assign is_addr = byte_done & (state_q == sst_pkg::ST_ADDR);
  assign is_data = byte_done & (state_q == sst_pkg::ST_DATA);

  for (genvar k = 0; k < sst_pkg::NUM_IDS; k++)
  begin : g_id_cmp
    assign id_eq[k] = ctrl_q[sst_pkg::CTRL_SEN] & (rx_byte[7:1] == id_q[k]);
  end

  // lowest index wins when two ids hold the same address
  assign id_idx = id_eq[0] ? 2'b00 : id_eq[1] ? 2'b01 : id_eq[2] ? 2'b10 : 2'b11;
  assign hit_start_byte = is_addr & (rx_byte == sst_pkg::START_BYTE);
  assign hit_gc_addr = is_addr & ctrl_q[sst_pkg::CTRL_GCEN]
    & (rx_byte == sst_pkg::GC_ADDR);
  assign hit_id = is_addr & (|id_eq) & ~hit_start_byte & ~hit_gc_addr;

  assign gc_cmd = is_data & gc_phase_q;
  assign gc_rst_cmd = gc_cmd & (rx_byte == sst_pkg::GC_RESET);
  assign gc_prog_cmd = gc_cmd & (rx_byte == sst_pkg::GC_PROG);
  assign gc_hw_cmd = gc_cmd & ~gc_rst_cmd & ~gc_prog_cmd
    & ctrl_q[sst_pkg::CTRL_GCEN] & ctrl_q[sst_pkg::CTRL_HGCEN]
    & (rx_byte == alt_q);
  assign gc_any = gc_rst_cmd | gc_prog_cmd | gc_hw_cmd;
  assign ack_now = hit_gc_addr | hit_id | (is_data & (~gc_phase_q | gc_any));

  always_comb
  begin
    next_state = state_q;
    case (state_q)
      sst_pkg::ST_ADDR:
      begin
        if (hit_gc_addr | (hit_id & ~rx_byte[0]))
          next_state = sst_pkg::ST_DATA;
        else
          next_state = sst_pkg::ST_SKIP;
      end
      sst_pkg::ST_DATA:
      begin
        if (!ack_now)
          next_state = sst_pkg::ST_SKIP;
      end
      default:
      begin
        next_state = state_q;
      end
    endcase
  end

  // ****************************************
  // receiver and acknowledge drive
  // ****************************************
  // ack is driven from the scl fall after bit 8 to the fall after bit 9;
  // reads are acked but no data is sent back, so the master sees 0xff
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_q <= sst_pkg::ST_IDLE;
      bit_cnt_q <= 3'h0;
      shift_q <= 7'h00;
      ack_slot_q <= 1'b0;
      ack_pend_q <= 1'b0;
      sda_oe_q <= 1'b0;
      gc_phase_q <= 1'b0;
    end
    else if (ev.stop | ev.start)
    begin
      state_q <= ev.stop ? sst_pkg::ST_IDLE : sst_pkg::ST_ADDR;
      bit_cnt_q <= 3'h0;
      ack_slot_q <= 1'b0;
      ack_pend_q <= 1'b0;
      sda_oe_q <= 1'b0;
      gc_phase_q <= 1'b0;
    end
    else
    begin
      if (rx_bit)
      begin
        shift_q <= rx_byte[6:0];
        bit_cnt_q <= bit_cnt_q + 3'h1;
      end
      if (byte_done)
      begin
        state_q <= next_state;
        ack_slot_q <= 1'b1;
        ack_pend_q <= ack_now;
        gc_phase_q <= hit_gc_addr;
      end
      else if (ev.rise & ack_slot_q)
      begin
        ack_slot_q <= 1'b0;
      end
      if (ev.fall)
      begin
        sda_oe_q <= ack_pend_q;
        ack_pend_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // apb decode
  // ****************************************
  logic acc_first;
  logic acc_done;
  logic sel_status;
  logic sel_ctrl;
  logic sel_alt;
  logic sel_rxd;
  logic [sst_pkg::NUM_IDS-1:0] sel_id;
  logic hit_map;
  logic wr_ctrl;
  logic wr_alt;
  logic gcclr_wr;
  logic rd_status;
  logic rd_rxd;
  logic [31:0] rd_mux;
  logic [31:0] id_rd [sst_pkg::NUM_IDS+1];
  sst_pkg::sst_status_t status_w;

  // first access cycle snapshots read data; the following edge completes
  assign acc_first = psel & penable & ~pready_q;
  assign acc_done = psel & penable & pready_q;
  assign sel_status = (paddr == sst_pkg::OFS_STATUS);
  assign sel_ctrl = (paddr == sst_pkg::OFS_CTRL);
  assign sel_alt = (paddr == sst_pkg::OFS_ALT);
  assign sel_rxd = (paddr == sst_pkg::OFS_RXD);
  assign hit_map = sel_status | sel_ctrl | sel_alt | sel_rxd | (|sel_id);
  assign wr_ctrl = acc_done & pwrite & sel_ctrl;
  assign wr_alt = acc_done & pwrite & sel_alt;
  assign gcclr_wr = wr_ctrl & pwdata[sst_pkg::CTRL_GCCLR];
  assign rd_status = acc_first & ~pwrite & sel_status;
  assign rd_rxd = acc_first & ~pwrite & sel_rxd;

  assign id_rd[0] = 32'h0000_0000;
  for (genvar k = 0; k < sst_pkg::NUM_IDS; k++)
  begin : g_id_sel
    assign sel_id[k] = (paddr == sst_pkg::OFS_ID0 + 8'(4 * k));
    assign id_rd[k+1] = id_rd[k] | (sel_id[k] ? {25'h000_0000, id_q[k]} : 32'h0000_0000);
  end

  assign status_w.rsvd = 1'b0;
  assign status_w.start = start_q;
  assign status_w.reps = reps_q;
  assign status_w.mid = mid_q;
  assign status_w.ss = ss_q;
  assign status_w.gck = gck_q;
  assign status_w.gc = gc_q;
  assign status_w.low = 7'h00;

  assign rd_mux = sel_status ? {16'h0000, status_w}
    : sel_ctrl ? {16'h0000, ctrl_q}
    : sel_alt ? {24'h00_0000, alt_q}
    : sel_rxd ? {23'h00_0000, rxd_valid_q, rxd_q}
    : id_rd[sst_pkg::NUM_IDS];

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= acc_first;
      pslverr_q <= acc_first & ~hit_map;
      prdata_q <= (acc_first & ~pwrite & hit_map) ? rd_mux : 32'h0000_0000;
    end
  end

  // ****************************************
  // control, id and alternate id registers
  // ****************************************
  // a general call reset beats a software write in the same cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= sst_pkg::CTRL_RST;
      alt_q <= sst_pkg::ALT_RST;
      for (int i = 0; i < sst_pkg::NUM_IDS; i++)
        id_q[i] <= sst_pkg::ID_RST;
    end
    else if (gc_rst_cmd)
    begin
      ctrl_q <= sst_pkg::CTRL_RST;
      alt_q <= sst_pkg::ALT_RST;
      for (int i = 0; i < sst_pkg::NUM_IDS; i++)
        id_q[i] <= sst_pkg::ID_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= pwdata[15:0] & sst_pkg::CTRL_WMASK;
      if (wr_alt)
        alt_q <= pwdata[7:0];
      for (int i = 0; i < sst_pkg::NUM_IDS; i++)
        if (acc_done & pwrite & sel_id[i])
          id_q[i] <= pwdata[6:0];
    end
  end

  // ****************************************
  // receive holding register
  // ****************************************
  // single byte only: a new byte overwrites one not yet read
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rxd_q <= sst_pkg::RXD_RST;
      rxd_valid_q <= 1'b0;
    end
    else if (gc_hw_cmd | (is_data & ~gc_phase_q))
    begin
      rxd_q <= rx_byte;
      rxd_valid_q <= 1'b1;
    end
    else if (rd_rxd | gc_rst_cmd)
    begin
      rxd_valid_q <= 1'b0;
    end
  end

  // ****************************************
  // status flags, set wins over clear
  // ****************************************
  logic ss_set;
  logic ss_d;

  assign ss_set = ev.stop & session_hit_q;
  assign ss_d = ss_set | (ss_q & ~rd_status & ~gc_rst_cmd);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      start_q <= 1'b0;
      reps_q <= 1'b0;
      mid_q <= 2'b00;
      ss_q <= 1'b0;
      session_hit_q <= 1'b0;
      gck_q <= sst_pkg::GCK_NONE;
      gc_q <= 1'b0;
      stop_irq_q <= 1'b0;
    end
    else
    begin
      if (hit_id | hit_start_byte | hit_gc_addr)
        start_q <= 1'b1;
      else if (ev.stop | gc_rst_cmd)
        start_q <= 1'b0;
      if (ev.start & bus_busy)
        reps_q <= 1'b1;
      else if (ev.stop | rd_status | gc_rst_cmd)
        reps_q <= 1'b0;
      if (hit_id)
        mid_q <= id_idx;
      else if (gc_rst_cmd)
        mid_q <= 2'b00;
      ss_q <= ss_d;
      if (hit_id)
        session_hit_q <= 1'b1;
      else if (ev.stop | ev.start)
        session_hit_q <= 1'b0;
      // a general call reset loads the kind field with reset instead of clearing it
      if (gc_rst_cmd)
        gck_q <= sst_pkg::GCK_RESET;
      else if (gc_prog_cmd)
        gck_q <= sst_pkg::GCK_PROG;
      else if (gc_hw_cmd)
        gck_q <= sst_pkg::GCK_ALT;
      else if (gcclr_wr)
        gck_q <= sst_pkg::GCK_NONE;
      if (gc_any)
        gc_q <= 1'b1;
      else if (gcclr_wr)
        gc_q <= 1'b0;
      stop_irq_q <= ss_d & ctrl_q[sst_pkg::CTRL_SSENI];
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  logic sda_o_q;

  // open-drain: only ever pulls low
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      sda_o_q <= 1'b0;
    else
      sda_o_q <= 1'b0;
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign sda_o = sda_o_q;
  assign sda_oe = sda_oe_q;
  assign stop_irq = stop_irq_q;

endmodule : sst_tracker

// [dv/sst_tracker_monitor.sv]
// concurrent checks on the tracker's apb and pin ports
// assumes it is bound onto sst_tracker and sees only that module's ports
`timescale 1ns/1ps
module sst_tracker_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sst_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // i2c pins and interrupt
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic stop_irq
);
  // *****
  // checks
  // *****
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence setup_then_access;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence status_read_done;
    pready && !pwrite && paddr == sst_pkg::OFS_STATUS;
  endsequence
  wire ctrl_rd = pready && !pwrite && paddr == sst_pkg::OFS_CTRL;
  wire bad_addr = paddr > sst_pkg::OFS_RXD || paddr[1:0] != 2'b00;
  AST_ONE_WAIT: assert property (setup_then_access |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  AST_ERR_DECODE: assert property (pready |-> pslverr == bad_addr)
    else $error("pslverr does not match address decode");
  AST_RDATA_QUIET: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("prdata not zero outside a completion");
  AST_RSVD_ZERO: assert property (status_read_done |-> prdata[31:15] == 17'h0_0000)
    else $error("reserved status bits not zero");
  AST_IRQ_READ_CLEAR: assert property (status_read_done |-> ##[1:2] !stop_irq)
    else $error("stop irq still high after status read");
  AST_CTRL_CLEAR_ZERO: assert property (ctrl_rd |-> prdata[sst_pkg::CTRL_GCCLR] == 1'b0)
    else $error("clear bit reads back as one");
  AST_ACK_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_i && !$past(scl_i))
    else $error("sda driver changed while scl high");
  AST_IRQ_AT_STOP: assert property ($rose(stop_irq) |-> scl_i)
    else $error("stop irq rose with scl low");
  AST_SDA_O_LOW: assert property (!sda_o)
    else $error("sda output not low");
endmodule : sst_tracker_monitor

bind sst_tracker sst_tracker_monitor mon_u (.clock(clock), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .stop_irq(stop_irq));

// [dv/sst_i2c_master.sv]
// behavioural i2c bus master: drives scl, pulls sda low
// assumes a pull-up on sda; scl stands high between frames
`timescale 1ns/1ps
module sst_i2c_master (
  // bus lines
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  localparam time Q = 50ns;
  // all delays are whole clock periods, so line changes are non-blocking
  // to keep them clear of the same-step sampling race
  initial
  begin
    scl <= 1'b1;
    sda_pull <= 1'b0;
  end
  task automatic start_c;
    sda_pull <= 1'b0;
    #Q scl <= 1'b1;
    #Q sda_pull <= 1'b1;
    #Q scl <= 1'b0;
    #Q;
  endtask : start_c
  task automatic stop_c;
    sda_pull <= 1'b1;
    #Q scl <= 1'b1;
    #Q sda_pull <= 1'b0;
    #(2*Q);
  endtask : stop_c
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sda_pull <= ~b[i];
      #Q scl <= 1'b1;
      #(2*Q) scl <= 1'b0;
      #Q;
    end
    sda_pull <= 1'b0;
    // low phase stretched so the slave's ack lands and leaves while scl is low
    #(3*Q) scl <= 1'b1;
    #Q ack = ~sda;
    #Q scl <= 1'b0;
    #(4*Q);
  endtask : send_byte
endmodule : sst_i2c_master

// [dv/tb.sv]
// self-checking bench for sst_tracker: apb master, i2c partner, status model
// assumes sst_i2c_master as bus partner and the bound checker
`timescale 1ns/1ps
module tb;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, scl, pull, sda_oe, sda_o, stop_irq;
  logic [7:0] paddr, alt;
  logic [31:0] pwdata, prdata, rd;
  logic err, ack;
  logic [6:0] id [4];
  wire sda = !(pull || sda_oe);
  int errors, n_compared, st, reps, mid, ss, gck, gc;
  logic [15:0] tc_ctl [5] = '{16'h0101, 16'h0105, 16'h0105, 16'h010d, 16'h0105};
  logic [7:0] tc_b2 [5] = '{8'h04, 8'h04, 8'hff, 8'hff, 8'h06};
  logic tc_a1 [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  logic tc_a2 [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  int tc_gk [5] = '{0, 2, 0, 3, 1};
  sst_tracker dut_u (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .stop_irq(stop_irq));
  sst_i2c_master m_u (.scl(scl), .sda_pull(pull), .sda(sda));
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // *****
  // tasks
  // *****
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      errors++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_status;
    apb(1'b0, sst_pkg::OFS_STATUS, 32'h0000_0000);
    check("status", rd, {16'h0, 1'b0, st[0], reps[0], mid[1:0], ss[0], gck[1:0], gc[0], 7'h0});
    reps = 0;
    ss = 0;
  endtask : rd_status
  task automatic settle;
    repeat (10) @(posedge clock);
  endtask : settle
  // *****
  // main sequence
  // *****
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    {errors, n_compared, st, reps, mid, ss, gck, gc} = '0;
    void'($urandom(56));
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    settle();
    rd_status();
    apb(1'b0, 8'h20, 32'h0000_0000);
    check("slverr", {31'h0, err}, 32'h0000_0001);
    apb(1'b0, 8'h06, 32'h0000_0000);
    check("slverr", {31'h0, err}, 32'h0000_0001);
    check("rdata", rd, 32'h0000_0000);
    $display("test reset done");
    for (int k = 0; k < 4; k++)
    begin
      id[k] = 7'(8'h10 + k * 8 + $urandom_range(7));
      apb(1'b1, sst_pkg::OFS_ID0 + 8'(4 * k), {25'h0, id[k]});
    end
    apb(1'b1, sst_pkg::OFS_CTRL, 32'h0000_0101);
    for (int k = 0; k < 4; k++)
    begin
      m_u.start_c();
      m_u.send_byte({id[k], 1'b0}, ack);
      check("ack", {31'h0, ack}, 32'h0000_0001);
      st = 1;
      mid = k;
      settle();
      rd_status();
      m_u.send_byte(8'($urandom), ack);
      m_u.stop_c();
      settle();
      st = 0;
      ss = 1;
      check("irq", {31'h0, stop_irq}, 32'h0000_0001);
      rd_status();
      settle();
      check("irq", {31'h0, stop_irq}, 32'h0000_0000);
      rd_status();
    end
    $display("test address match done");
    m_u.start_c();
    m_u.send_byte({id[1], 1'b0}, ack);
    m_u.start_c();
    m_u.send_byte({id[2], 1'b0}, ack);
    st = 1;
    reps = 1;
    mid = 2;
    settle();
    rd_status();
    rd_status();
    m_u.start_c();
    m_u.send_byte({id[3], 1'b0}, ack);
    m_u.stop_c();
    settle();
    st = 0;
    mid = 3;
    ss = 1;
    rd_status();
    m_u.start_c();
    m_u.send_byte(sst_pkg::START_BYTE, ack);
    st = 1;
    settle();
    rd_status();
    m_u.stop_c();
    st = 0;
    settle();
    rd_status();
    $display("test repeated start done");
    alt = 8'($urandom_range(16, 127)) | 8'h01;
    apb(1'b1, sst_pkg::OFS_ALT, {24'h0, alt});
    for (int c = 0; c < 5; c++)
    begin
      apb(1'b1, sst_pkg::OFS_CTRL, {16'h0, tc_ctl[c] | 16'h0010});
      gck = 0;
      gc = 0;
      rd_status();
      m_u.start_c();
      m_u.send_byte(sst_pkg::GC_ADDR, ack);
      check("ack", {31'h0, ack}, {31'h0, tc_a1[c]});
      st = tc_a1[c];
      settle();
      rd_status();
      m_u.send_byte(tc_b2[c] == 8'hff ? alt : tc_b2[c], ack);
      check("ack", {31'h0, ack}, {31'h0, tc_a2[c]});
      m_u.stop_c();
      settle();
      st = 0;
      if (tc_gk[c] != 0)
      begin
        gck = tc_gk[c];
        gc = 1;
      end
      if (c == 4)
        mid = 0;
      rd_status();
      if (c == 3)
      begin
        apb(1'b0, sst_pkg::OFS_RXD, 32'h0000_0000);
        check("rxd", rd, {23'h0, 1'b1, alt});
      end
    end
    apb(1'b0, sst_pkg::OFS_CTRL, 32'h0000_0000);
    check("ctrl", rd, 32'h0000_0000);
    apb(1'b0, sst_pkg::OFS_ID0, 32'h0000_0000);
    check("id0", rd, 32'h0000_0000);
    apb(1'b1, sst_pkg::OFS_CTRL, 32'h0000_0115);
    apb(1'b0, sst_pkg::OFS_CTRL, 32'h0000_0000);
    check("ctrl", rd, 32'h0000_0105);
    $display("test general call done");
    give_verdict();
  end
endmodule : tb
